// ===== rtl/iwb_defs.svh
`ifndef IWB_DEFS_SVH
`define IWB_DEFS_SVH

// register addresses
`define IWB_ADDR_WIPER 8'h00
`define IWB_ADDR_REVISION 8'h01
`define IWB_ADDR_GP_FIRST 8'h02
`define IWB_ADDR_GP_LAST 8'h06
`define IWB_ADDR_RESERVED 8'h07
`define IWB_ADDR_ACCESS 8'h08

// field positions and codes
`define IWB_VOL_BIT 7
`define IWB_ID_PREFIX 7'h28
`define IWB_GP_COUNT 5

// reset and shipped values
`define IWB_WIPER_RESET 8'h80
`define IWB_IVR_RESET 8'h80
`define IWB_GP_RESET 8'h00
`define IWB_VOL_RESET 1'b0

// timing: figures in their own unit, counts derived from the clock period
`define IWB_CLK_PERIOD_NS 4
`define IWB_NV_WRITE_TIME_MS 12
`define IWB_NV_WRITE_MAX_MS 20
`define IWB_RECALL_TIME_NS 1000
`define IWB_MBB_TIME_NS 20
`define IWB_NV_WRITE_CYCLES ((`IWB_NV_WRITE_TIME_MS * 1000000) / `IWB_CLK_PERIOD_NS)
`define IWB_NV_WRITE_MAX_CYCLES ((`IWB_NV_WRITE_MAX_MS * 1000000) / `IWB_CLK_PERIOD_NS)
`define IWB_RECALL_CYCLES ((`IWB_RECALL_TIME_NS + `IWB_CLK_PERIOD_NS - 1) / `IWB_CLK_PERIOD_NS)
`define IWB_MBB_CYCLES ((`IWB_MBB_TIME_NS + `IWB_CLK_PERIOD_NS - 1) / `IWB_CLK_PERIOD_NS)

`endif

// ===== rtl/iwb_edge_detect.sv
`timescale 1ns/1ps
`default_nettype none

module iwb_edge_detect (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic sig_in,
    output logic prev,
    output logic rise,
    output logic fall
);

    logic prev_reg;
    logic prev_next;

    // previous sample; idle bus lines sit high under the pull-up
    always_comb
    begin
        prev_next = sig_in;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            prev_reg <= 1'b1;
        else
            prev_reg <= prev_next;
    end

    // edges are one-cycle strobes against the previous sample
    assign prev = prev_reg;
    assign rise = sig_in & ~prev_reg;
    assign fall = ~sig_in & prev_reg;

endmodule : iwb_edge_detect

`default_nettype wire

// ===== rtl/iwb_make_break.sv
`timescale 1ns/1ps
`default_nettype none
`include "iwb_defs.svh"

module iwb_make_break #(
    parameter int W = 8,
    parameter int OVERLAP_CYCLES = `IWB_MBB_CYCLES,
    parameter logic [W-1:0] RESET_CODE = `IWB_WIPER_RESET
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [W-1:0] code_in,
    output logic [W-1:0] tap_main,
    output logic [W-1:0] tap_make,
    output logic tap_make_en
);

    logic [W-1:0] main_reg, main_next;
    logic [W-1:0] make_reg, make_next;
    logic en_reg, en_next;
    logic [7:0] cnt_reg, cnt_next;

    // new tap closes first; old one opens only after the overlap
    always_comb
    begin
        main_next = main_reg;
        make_next = make_reg;
        en_next = en_reg;
        cnt_next = cnt_reg;
        if (!en_reg)
        begin
            if (code_in != main_reg)
            begin
                make_next = code_in;
                en_next = 1'b1;
                cnt_next = 8'(OVERLAP_CYCLES - 1);
            end
        end
        else if (cnt_reg == 8'h00)
        begin
            main_next = make_reg;
            en_next = 1'b0;
        end
        else
            cnt_next = cnt_reg - 8'h01;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            main_reg <= RESET_CODE;
            make_reg <= RESET_CODE;
            en_reg <= 1'b0;
            cnt_reg <= 8'h00;
        end
        else
        begin
            main_reg <= main_next;
            make_reg <= make_next;
            en_reg <= en_next;
            cnt_reg <= cnt_next;
        end
    end

    assign tap_main = main_reg;
    assign tap_make = make_reg;
    assign tap_make_en = en_reg;

    chk_make_before_break: assert property (@(posedge clk) disable iff (!arst_n)
        $changed(main_reg) |-> $past(en_reg) && ($past(make_reg) == main_reg))
        else $error("main tap moved without the new tap made first");

endmodule : iwb_make_break

`default_nettype wire

// ===== rtl/iwb_pkg.sv
package iwb_pkg;

    // serial slave phases
    typedef enum logic [2:0] {
        st_idle = 3'h0,
        st_id = 3'h1,
        st_addr = 3'h2,
        st_wdata = 3'h3,
        st_ack = 3'h4,
        st_rdata = 3'h5,
        st_rack = 3'h6
    } iwb_state_t;

endpackage : iwb_pkg

// ===== rtl/iwb_wiper_bank.sv
// Functional notes
// - code 00h sits nearest the low terminal, FFh nearest high, monotonic between.
// - wiper tap comes only from the 8-bit volatile wiper register.
// - incoming serial bits are sampled on the rising serial clock edge.
// - read data on the data line changes only after serial clock falls.
// - data line is open drain: pull low or release, never drive high.
// - write-lock low discards write data; no contents change.
// - power-up forces the wiper register to 80h first.
// - once storage is readable, wiper loads from the initial-position store.
// - initial-position store ships holding 80h.
// - wiper and initial-position store share address 0, chosen by volatile-select.
// - volatile-select clear reaches stored bytes; set reaches only the wiper.
// - a write to the initial-position store also lands in the wiper.
// - volatile-select is zero after power-up.
// - address 1 is a read-only revision code; writes do nothing.
// - five stored general bytes at 2..6, only with volatile-select clear.
// - access-select register is volatile, at address 8.
// - a new tap is connected before the old tap opens.
// - identification byte must carry 0101000 on top; low bit picks read.
// - write to address 0 with access-select zero starts a stored write at stop.
// - during a stored write the bus is ignored and data released.
// - each stored write finishes within 20 ms of its stop.
`timescale 1ns/1ps
`default_nettype none
`include "iwb_defs.svh"

module iwb_wiper_bank #(
    parameter int NV_WRITE_CYCLES = `IWB_NV_WRITE_CYCLES,
    parameter logic [7:0] REVISION_CODE = 8'h5A, // arbitrary value
    parameter logic [7:0] GP_RESET = `IWB_GP_RESET
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    input wire logic write_lock_n,
    output logic [7:0] wiper_code,
    output logic [7:0] tap_main,
    output logic [7:0] tap_make,
    output logic tap_make_en,
    output logic nv_busy
);

    localparam int RECALL_CYCLES = `IWB_RECALL_CYCLES;
    localparam int NV_MAX_CYCLES = `IWB_NV_WRITE_MAX_CYCLES;

    // bus and register state
    iwb_pkg::iwb_state_t state_reg, state_next;
    iwb_pkg::iwb_state_t after_ack_reg, after_ack_next;
    logic [2:0] cnt_reg, cnt_next;
    logic done_reg, done_next;
    logic [7:0] shift_reg, shift_next;
    logic [7:0] addr_reg, addr_next;
    logic oe_n_reg, oe_n_next;
    logic master_ack_reg, master_ack_next;
    logic [7:0] wiper_reg, wiper_next;
    logic vol_reg, vol_next;
    logic [7:0] ivr_reg, ivr_next;
    logic [7:0] gp_reg [0:`IWB_GP_COUNT-1];
    logic [7:0] gp_next [0:`IWB_GP_COUNT-1];
    logic pend_valid_reg, pend_valid_next;
    logic [7:0] pend_addr_reg, pend_addr_next;
    logic [7:0] pend_data_reg, pend_data_next;
    logic sda_out_reg;

    // power-up and stored-write timing state
    logic ready_reg, ready_next;
    logic [15:0] recall_cnt_reg, recall_cnt_next;
    logic nv_busy_reg, nv_busy_next;
    logic [31:0] nv_timer_reg, nv_timer_next;

    logic scl_prev, scl_rise, scl_fall;
    logic sda_rise, sda_fall;
    logic bus_active, start_ev, stop_ev, rise_ev, fall_ev;
    logic recall_done, nv_done, nv_start, wr_ivr;
    logic [7:0] rd_data;
    logic [2:0] rd_idx, pend_idx;
    logic addr_is_gp;

    iwb_edge_detect u_scl_edge (
        .clk(clk),
        .arst_n(arst_n),
        .sig_in(scl_in),
        .prev(scl_prev),
        .rise(scl_rise),
        .fall(scl_fall)
    );

    iwb_edge_detect u_sda_edge (
        .clk(clk),
        .arst_n(arst_n),
        .sig_in(sda_in),
        .prev(),
        .rise(sda_rise),
        .fall(sda_fall)
    );

    // bus deaf until recall is over and while a stored write runs
    assign bus_active = ready_reg & ~nv_busy_reg;
    assign start_ev = bus_active & sda_fall & scl_in & scl_prev;
    assign stop_ev = bus_active & sda_rise & scl_in & scl_prev;
    assign rise_ev = bus_active & scl_rise;
    assign fall_ev = bus_active & scl_fall;
    assign recall_done = ~ready_reg & (recall_cnt_reg == 16'h0000);
    assign nv_done = nv_busy_reg & (nv_timer_reg == 32'h00000000);
    assign addr_is_gp = (addr_reg >= `IWB_ADDR_GP_FIRST) && (addr_reg <= `IWB_ADDR_GP_LAST);
    assign rd_idx = addr_reg[2:0] - 3'h2;
    assign pend_idx = pend_addr_reg[2:0] - 3'h2;

    // read mux; volatile-select steers address 0 and hides the stored bytes
    always_comb
    begin
        rd_data = 8'h00;
        if (addr_reg == `IWB_ADDR_WIPER)
            rd_data = vol_reg ? wiper_reg : ivr_reg;
        else if (addr_reg == `IWB_ADDR_REVISION)
            rd_data = REVISION_CODE;
        else if (addr_is_gp && !vol_reg)
            rd_data = gp_reg[rd_idx];
        else if (addr_reg == `IWB_ADDR_ACCESS)
            rd_data = {vol_reg, 7'h00};
    end

    // serial slave and register writes
    always_comb
    begin
        state_next = state_reg;
        after_ack_next = after_ack_reg;
        cnt_next = cnt_reg;
        done_next = done_reg;
        shift_next = shift_reg;
        addr_next = addr_reg;
        oe_n_next = oe_n_reg;
        master_ack_next = master_ack_reg;
        wiper_next = wiper_reg;
        vol_next = vol_reg;
        ivr_next = ivr_reg;
        gp_next = gp_reg;
        pend_valid_next = pend_valid_reg;
        pend_addr_next = pend_addr_reg;
        pend_data_next = pend_data_reg;
        nv_start = 1'b0;
        wr_ivr = 1'b0;
        if (recall_done)
            wiper_next = ivr_reg;
        // self-timed store commits the held byte at the end of the cycle
        if (nv_done && pend_valid_reg)
        begin
            pend_valid_next = 1'b0;
            if (pend_addr_reg == `IWB_ADDR_WIPER)
                ivr_next = pend_data_reg;
            else
                gp_next[pend_idx] = pend_data_reg;
        end
        if (start_ev)
        begin
            // a fresh start without stop drops any held stored write
            state_next = iwb_pkg::st_id;
            cnt_next = 3'h0;
            done_next = 1'b0;
            oe_n_next = 1'b1;
            pend_valid_next = 1'b0;
        end
        else if (stop_ev)
        begin
            state_next = iwb_pkg::st_idle;
            oe_n_next = 1'b1;
            nv_start = pend_valid_reg;
        end
        else if (rise_ev)
        begin
            unique case (state_reg)
                iwb_pkg::st_id, iwb_pkg::st_addr, iwb_pkg::st_wdata:
                begin
                    shift_next = {shift_reg[6:0], sda_in};
                    cnt_next = cnt_reg + 3'h1;
                    done_next = (cnt_reg == 3'h7);
                end
                iwb_pkg::st_rdata:
                begin
                    cnt_next = cnt_reg + 3'h1;
                    done_next = (cnt_reg == 3'h7);
                end
                iwb_pkg::st_rack: master_ack_next = ~sda_in;
                iwb_pkg::st_idle, iwb_pkg::st_ack: ;
            endcase
        end
        else if (fall_ev)
        begin
            // every pull-down of the data line happens here, after a falling edge; start and stop only release it
            unique case (state_reg)
                iwb_pkg::st_idle: ;
                iwb_pkg::st_id:
                    if (done_reg)
                    begin
                        done_next = 1'b0;
                        if (shift_reg[7:1] == `IWB_ID_PREFIX)
                        begin
                            oe_n_next = 1'b0;
                            state_next = iwb_pkg::st_ack;
                            after_ack_next = shift_reg[0] ? iwb_pkg::st_rdata : iwb_pkg::st_addr;
                        end
                        else
                            state_next = iwb_pkg::st_idle;
                    end
                iwb_pkg::st_addr:
                    if (done_reg)
                    begin
                        done_next = 1'b0;
                        addr_next = shift_reg;
                        oe_n_next = 1'b0;
                        state_next = iwb_pkg::st_ack;
                        after_ack_next = iwb_pkg::st_wdata;
                    end
                iwb_pkg::st_wdata:
                    if (done_reg)
                    begin
                        done_next = 1'b0;
                        if (!write_lock_n)
                            state_next = iwb_pkg::st_idle;
                        else
                        begin
                            oe_n_next = 1'b0;
                            state_next = iwb_pkg::st_ack;
                            after_ack_next = iwb_pkg::st_wdata;
                            if (addr_reg == `IWB_ADDR_WIPER)
                            begin
                                wiper_next = shift_reg;
                                if (!vol_reg)
                                begin
                                    wr_ivr = 1'b1;
                                    pend_valid_next = 1'b1;
                                    pend_addr_next = addr_reg;
                                    pend_data_next = shift_reg;
                                end
                            end
                            else if (addr_is_gp && !vol_reg)
                            begin
                                pend_valid_next = 1'b1;
                                pend_addr_next = addr_reg;
                                pend_data_next = shift_reg;
                            end
                            else if (addr_reg == `IWB_ADDR_ACCESS)
                                vol_next = shift_reg[`IWB_VOL_BIT];
                            // other addresses are acked but change nothing
                        end
                    end
                iwb_pkg::st_ack:
                begin
                    oe_n_next = 1'b1;
                    state_next = after_ack_reg;
                    if (after_ack_reg == iwb_pkg::st_rdata)
                    begin
                        shift_next = rd_data;
                        oe_n_next = rd_data[7];
                    end
                end
                iwb_pkg::st_rdata:
                    if (done_reg)
                    begin
                        done_next = 1'b0;
                        oe_n_next = 1'b1;
                        addr_next = addr_reg + 8'h01;
                        state_next = iwb_pkg::st_rack;
                    end
                    else
                    begin
                        shift_next = {shift_reg[6:0], 1'b0};
                        oe_n_next = shift_reg[6];
                    end
                iwb_pkg::st_rack:
                    if (master_ack_reg)
                    begin
                        shift_next = rd_data;
                        oe_n_next = rd_data[7];
                        state_next = iwb_pkg::st_rdata;
                    end
                    else
                        state_next = iwb_pkg::st_idle;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_reg <= iwb_pkg::st_idle;
            after_ack_reg <= iwb_pkg::st_idle;
            cnt_reg <= 3'h0;
            done_reg <= 1'b0;
            shift_reg <= 8'h00;
            addr_reg <= 8'h00;
            oe_n_reg <= 1'b1;
            master_ack_reg <= 1'b0;
            wiper_reg <= `IWB_WIPER_RESET;
            vol_reg <= `IWB_VOL_RESET;
            ivr_reg <= `IWB_IVR_RESET;
            for (int i = 0; i < `IWB_GP_COUNT; i++)
                gp_reg[i] <= GP_RESET;
            pend_valid_reg <= 1'b0;
            pend_addr_reg <= 8'h00;
            pend_data_reg <= 8'h00;
            sda_out_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            after_ack_reg <= after_ack_next;
            cnt_reg <= cnt_next;
            done_reg <= done_next;
            shift_reg <= shift_next;
            addr_reg <= addr_next;
            oe_n_reg <= oe_n_next;
            master_ack_reg <= master_ack_next;
            wiper_reg <= wiper_next;
            vol_reg <= vol_next;
            ivr_reg <= ivr_next;
            gp_reg <= gp_next;
            pend_valid_reg <= pend_valid_next;
            pend_addr_reg <= pend_addr_next;
            pend_data_reg <= pend_data_next;
            sda_out_reg <= 1'b0; // open drain only ever pulls low
        end
    end

    // recall delay, then the self-timed stored write
    always_comb
    begin
        ready_next = ready_reg;
        recall_cnt_next = recall_cnt_reg;
        nv_busy_next = nv_busy_reg;
        nv_timer_next = nv_timer_reg;
        if (!ready_reg)
        begin
            if (recall_cnt_reg == 16'h0000)
                ready_next = 1'b1;
            else
                recall_cnt_next = recall_cnt_reg - 16'h0001;
        end
        if (nv_start)
        begin
            nv_busy_next = 1'b1;
            nv_timer_next = 32'(NV_WRITE_CYCLES - 1);
        end
        else if (nv_busy_reg)
        begin
            if (nv_timer_reg == 32'h00000000)
                nv_busy_next = 1'b0;
            else
                nv_timer_next = nv_timer_reg - 32'h00000001;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ready_reg <= 1'b0;
            recall_cnt_reg <= 16'(RECALL_CYCLES - 1);
            nv_busy_reg <= 1'b0;
            nv_timer_reg <= 32'h00000000;
        end
        else
        begin
            ready_reg <= ready_next;
            recall_cnt_reg <= recall_cnt_next;
            nv_busy_reg <= nv_busy_next;
            nv_timer_reg <= nv_timer_next;
        end
    end

    // wiper code drives the tap switches through make-before-break
    iwb_make_break #(
        .W(8)
    ) u_make_break (
        .clk(clk),
        .arst_n(arst_n),
        .code_in(wiper_reg),
        .tap_main(tap_main),
        .tap_make(tap_make),
        .tap_make_en(tap_make_en)
    );

    assign sda_out = sda_out_reg;
    assign sda_oe_n = oe_n_reg;
    assign wiper_code = wiper_reg;
    assign nv_busy = nv_busy_reg;

    chk_drive_after_fall: assert property (@(posedge clk) disable iff (!arst_n)
        $fell(oe_n_reg) |-> $past(scl_fall))
        else $error("data line pulled low without a preceding clock fall");

    chk_sample_on_rise: assert property (@(posedge clk) disable iff (!arst_n)
        (rise_ev && (state_reg == iwb_pkg::st_id || state_reg == iwb_pkg::st_addr)) |=>
        (shift_reg[0] == $past(sda_in)))
        else $error("serial bit not sampled on rising clock");

    chk_lock_holds: assert property (@(posedge clk) disable iff (!arst_n)
        (ready_reg && !write_lock_n) |=> ($stable(wiper_reg) && $stable(vol_reg)))
        else $error("register changed while write lock low");

    chk_powerup_mid: assert property (@(posedge clk) disable iff (!arst_n)
        !ready_reg |-> (wiper_reg == 8'h80))
        else $error("wiper not mid-scale during power-up");

    chk_recall_load: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(ready_reg) |-> (wiper_reg == ivr_reg))
        else $error("wiper not loaded from stored value");

    chk_ivr_copy: assert property (@(posedge clk) disable iff (!arst_n)
        wr_ivr |=> ((wiper_reg == $past(shift_reg)) && pend_valid_reg))
        else $error("stored-position write not copied to wiper");

    chk_busy_released: assert property (@(posedge clk) disable iff (!arst_n)
        nv_busy_reg |-> (oe_n_reg && (state_reg == iwb_pkg::st_idle)))
        else $error("bus active during stored write");

    chk_nv_bound: assert property (@(posedge clk) disable iff (!arst_n)
        nv_busy_reg |-> (nv_timer_reg < 32'(NV_MAX_CYCLES)))
        else $error("stored write exceeds its time bound");

    chk_id_reject: assert property (@(posedge clk) disable iff (!arst_n)
        (fall_ev && state_reg == iwb_pkg::st_id && done_reg && shift_reg[7:1] != 7'h28) |=>
        (state_reg == iwb_pkg::st_idle && oe_n_reg))
        else $error("foreign identification byte acknowledged");

    chk_nv_start_stop: assert property (@(posedge clk) disable iff (!arst_n)
        (stop_ev && pend_valid_reg) |=> (nv_busy_reg && nv_timer_reg == 32'(NV_WRITE_CYCLES - 1)))
        else $error("stop did not start stored write");

endmodule : iwb_wiper_bank

`default_nettype wire

// ===== verif/iwb_i2c_master.sv
`timescale 1ns/1ps
`default_nettype none
// bus master model; lines change at the falling clk edge only
module iwb_i2c_master (
    input wire logic clk,
    input wire logic sda_in,
    output logic scl,
    output logic sda_m
);
    initial
    begin
        scl = 1'b1;
        sda_m = 1'b1;
    end
    // one half phase of 4 clk
    task automatic hp(input logic c, input logic d);
        scl = c;
        sda_m = d;
        repeat (4) @(negedge clk);
    endtask : hp
    // also serves as repeated start
    task automatic start();
        hp(1'b0, 1'b1);
        hp(1'b1, 1'b1);
        hp(1'b1, 1'b0);
        hp(1'b0, 1'b0);
    endtask : start
    task automatic stop();
        hp(1'b0, 1'b0);
        hp(1'b1, 1'b0);
        hp(1'b1, 1'b1);
    endtask : stop
    // eight bits msb first then the ack slot; data held across the rise
    task automatic xfer(input logic [7:0] d, input logic ak, output logic [7:0] r, output logic a);
        for (int i = 7; i >= 0; i--)
        begin
            hp(1'b0, d[i]);
            hp(1'b1, d[i]);
            r[i] = sda_in;
        end
        hp(1'b0, ak);
        hp(1'b1, ak);
        a = sda_in;
    endtask : xfer
endmodule : iwb_i2c_master
`default_nettype wire

// ===== verif/iwb_wiper_bank_tb.sv
`timescale 1ns/1ps
`default_nettype none
module iwb_wiper_bank_tb;
    localparam int NV = 20;
    localparam logic [7:0] REV = 8'hA5; // arbitrary revision value
    logic clk;
    logic arst_n;
    logic write_lock_n;
    logic scl;
    logic sda_m;
    logic sda_out;
    logic sda_oe_n;
    logic [7:0] wiper_code;
    logic nv_busy;
    logic [7:0] tap_main;
    logic [7:0] tap_make;
    logic tap_make_en;
    logic k;
    logic [7:0] r;
    int n_mismatch;
    int samples_checked;
    // wire level with pull-up
    wire logic sda = !sda_oe_n ? 1'b0 : sda_m;
    iwb_i2c_master m (.clk, .sda_in(sda), .scl, .sda_m);
    iwb_wiper_bank #(.NV_WRITE_CYCLES(NV), .REVISION_CODE(REV)) i_iwb_wiper_bank (.clk, .arst_n, .scl_in(scl),
        .sda_in(sda), .sda_out, .sda_oe_n, .write_lock_n, .wiper_code, .tap_main, .tap_make, .tap_make_en, .nv_busy);
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // k returns the ack of the data byte
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        m.start();
        m.xfer(8'h50, 1'b1, r, k);
        m.xfer(a, 1'b1, r, k);
        m.xfer(d, 1'b1, r, k);
        m.stop();
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        m.start();
        m.xfer(8'h50, 1'b1, r, k);
        m.xfer(a, 1'b1, r, k);
        m.start();
        m.xfer(8'h51, 1'b1, r, k);
        m.xfer(8'hFF, 1'b1, r, k);
        m.stop();
        chk(r, e);
    endtask : rd
    // bounded wait for the stored write to end
    task automatic nvwait();
        int n;
        n = 0;
        while (nv_busy === 1'b1 && n < NV + 8)
        begin
            @(negedge clk);
            n++;
        end
        chk({7'h0, nv_busy}, 8'h00);
    endtask : nvwait
    // acknowledge polling; only the first try falls inside the stored write
    task automatic poll();
        int n;
        n = 0;
        k = 1'b1;
        while (k !== 1'b0 && n < 8)
        begin
            m.start();
            m.xfer(8'h50, 1'b1, r, k);
            m.stop();
            n++;
        end
        chk({7'h0, k}, 8'h00);
    endtask : poll
    task automatic t_boot();
        chk(wiper_code, 8'h80);
        rd(8'h08, 8'h00);
        rd(8'h00, 8'h80);
        $display("test boot done");
    endtask : t_boot
    task automatic t_nv();
        wr(8'h00, 8'h42);
        chk({7'h0, k}, 8'h00);
        chk(wiper_code, 8'h42);
        chk(tap_main, 8'h42);
        chk(tap_make, 8'h42);
        chk({7'h0, tap_make_en}, 8'h00);
        chk({7'h0, nv_busy}, 8'h01);
        m.start();
        m.xfer(8'h50, 1'b1, r, k);
        chk({7'h0, k}, 8'h01);
        m.stop();
        nvwait();
        rd(8'h00, 8'h42);
        $display("test nv done");
    endtask : t_nv
    task automatic t_vol();
        wr(8'h08, 8'h80);
        rd(8'h08, 8'h80);
        wr(8'h00, 8'h11);
        chk(wiper_code, 8'h11);
        chk(tap_main, 8'h11);
        chk({7'h0, nv_busy}, 8'h00);
        wr(8'h02, 8'h55);
        rd(8'h00, 8'h11);
        wr(8'h08, 8'h00);
        rd(8'h00, 8'h42);
        rd(8'h02, 8'h00);
        $display("test vol done");
    endtask : t_vol
    task automatic t_mem();
        wr(8'h06, 8'h3C);
        poll();
        nvwait();
        rd(8'h06, 8'h3C);
        wr(8'h01, 8'h00);
        wr(8'h07, 8'h33);
        rd(8'h01, REV);
        rd(8'h07, 8'h00);
        $display("test mem done");
    endtask : t_mem
    task automatic t_lock();
        write_lock_n = 1'b0;
        wr(8'h00, 8'h77);
        chk({7'h0, k}, 8'h01);
        chk(wiper_code, 8'h11);
        write_lock_n = 1'b1;
        m.start();
        m.xfer(8'h52, 1'b1, r, k);
        chk({7'h0, k}, 8'h01);
        m.stop();
        chk({7'h0, sda_out}, 8'h00);
        $display("test lock done");
    endtask : t_lock
    // mid-run reset: wiper back to mid-scale, volatile-select cleared
    task automatic t_rst();
        wr(8'h08, 8'h80);
        arst_n = 1'b0;
        repeat (2) @(negedge clk);
        chk(wiper_code, 8'h80);
        arst_n = 1'b1;
        repeat (300) @(negedge clk);
        chk(tap_main, 8'h80);
        rd(8'h08, 8'h00);
        $display("test reset done");
    endtask : t_rst
    task automatic test_done();
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : test_done
    initial
    begin
        arst_n = 1'b0;
        write_lock_n = 1'b1;
        n_mismatch = 0;
        samples_checked = 0;
        repeat (12) @(negedge clk);
        arst_n = 1'b1;
        // recall delay before the first start
        repeat (300) @(negedge clk);
        t_boot();
        t_nv();
        t_vol();
        t_mem();
        t_lock();
        t_rst();
        test_done();
    end
    // watchdog, several times the expected run
    initial
    begin
        #300000;
        n_mismatch++;
        test_done();
    end
endmodule : iwb_wiper_bank_tb
`default_nettype wire
